// >>> src/aux_function_strobe_handshake.sv
/*
 Sends the M functions of a block to the machine logic controller in a
 before-move group and an after-move group, each with its own strobe,
 closing each by the done handshake or by a fixed strobe width.
 Assumes the block request, table writes and done input are synchronous
 to mclk, and that the partner keeps its side of the done handshake.
*/
`timescale 1ns/10ps
`include "aux_defs.svh"

module aux_function_strobe_handshake (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Block request from the interpreter
	input wire logic blk_valid,
	input wire logic [`AUX_NUM_CODES*`AUX_CODE_W-1:0] blk_codes,
	input wire logic [`AUX_NUM_CODES-1:0] blk_code_valid,
	input wire logic blk_motion,
	output logic blk_ready,
	// Axis move handshake
	output logic move_start,
	input wire logic move_done,
	// Configuration
	input wire aux_pkg::width_t min_handshake_width,
	input wire logic tbl_wr_en,
	input wire aux_pkg::m_code_t tbl_wr_code,
	input wire aux_pkg::tbl_entry_t tbl_wr_entry,
	// Partner side
	output aux_pkg::m_code_t m_code_out_1,
	output aux_pkg::m_code_t m_code_out_2,
	output aux_pkg::m_code_t m_code_out_3,
	output aux_pkg::m_code_t m_code_out_4,
	output aux_pkg::m_code_t m_code_out_5,
	output aux_pkg::m_code_t m_code_out_6,
	output aux_pkg::m_code_t m_code_out_7,
	output logic m_code_strobe,
	input wire logic aux_done_in
);

	////////////////////////////////////////////////////////////////////////
	// State

	aux_pkg::hs_state_e state_reg;
	aux_pkg::hs_state_e state_next;
	aux_pkg::width_t cnt_reg;
	aux_pkg::m_code_t code_reg [`AUX_NUM_CODES];
	aux_pkg::m_code_t bef_code_reg [`AUX_NUM_CODES];
	aux_pkg::m_code_t aft_code_reg [`AUX_NUM_CODES];
	logic [2:0] bef_n_reg;
	logic [2:0] aft_n_reg;
	logic bef_wait_reg;
	logic aft_wait_reg;
	logic phase_reg;
	logic motion_reg;
	logic [2:0] idx_reg;
	logic [`AUX_NUM_CODES*`AUX_CODE_W-1:0] blk_codes_reg;
	logic [`AUX_NUM_CODES-1:0] blk_vld_reg;
	logic strobe_reg;
	logic ready_reg;
	logic move_reg;

	////////////////////////////////////////////////////////////////////////
	// Table lookup and classification of the code under scan

	aux_pkg::m_code_t cur_code;
	aux_pkg::tbl_entry_t cur_entry;
	wire cur_valid;
	wire cur_after;
	wire cur_wait;

	assign cur_code = blk_codes_reg[idx_reg*`AUX_CODE_W +: `AUX_CODE_W];
	assign cur_valid = blk_vld_reg[idx_reg];

	aux_func_table u_table (
		.mclk(mclk),
		.reset_n(reset_n),
		.wr_en(tbl_wr_en),
		.wr_code(tbl_wr_code),
		.wr_entry(tbl_wr_entry),
		.rd_code(cur_code),
		.rd_entry(cur_entry)
	);

	// Undefined codes go before the move and wait for done
	assign cur_after = cur_entry[`AUX_ENT_DEFINED] &
		cur_entry[`AUX_ENT_AFTER];
	assign cur_wait = ~cur_entry[`AUX_ENT_DEFINED] |
		cur_entry[`AUX_ENT_WAIT];
	wire add_bef = (state_reg == aux_pkg::st_scan) & cur_valid & ~cur_after;
	wire add_aft = (state_reg == aux_pkg::st_scan) & cur_valid & cur_after;

	////////////////////////////////////////////////////////////////////////
	// Current group and handshake decisions

	wire [2:0] grp_n = phase_reg ? aft_n_reg : bef_n_reg;
	wire grp_wait = phase_reg ? aft_wait_reg : bef_wait_reg;
	wire cnt_zero = (cnt_reg == '0);
	wire in_gap = (state_reg == aux_pkg::st_gap);
	wire grp_empty = in_gap & (grp_n == 3'h0);
	// Strobe rises only after the low time has run out
	wire fire = in_gap & ~grp_empty & cnt_zero;
	wire hold_end = (state_reg == aux_pkg::st_hold) & cnt_zero;
	wire acked = (state_reg == aux_pkg::st_ack) & ~aux_done_in;
	wire in_done = (state_reg == aux_pkg::st_done);
	// Done accepted once it stayed high through a full width count
	wire done_end = in_done & aux_done_in & cnt_zero;
	wire done_low = in_done & ~aux_done_in;
	wire release_s = hold_end | done_end;
	// One counter serves strobe width, done width and strobe low time
	wire cnt_load = fire | release_s | acked | done_low;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			cnt_reg <= '0;
		else if (cnt_load)
			cnt_reg <= min_handshake_width;
		else if (!cnt_zero)
			cnt_reg <= cnt_reg - 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencing

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			aux_pkg::st_idle:
				if (blk_valid)
					state_next = aux_pkg::st_scan;
			aux_pkg::st_scan:
				if (idx_reg == `AUX_LAST_IDX)
					state_next = aux_pkg::st_gap;
			aux_pkg::st_gap:
				if (grp_empty)
					state_next = aux_pkg::st_next;
				else if (fire)
					state_next = grp_wait ? aux_pkg::st_ack :
						aux_pkg::st_hold;
			aux_pkg::st_hold:
				if (hold_end)
					state_next = aux_pkg::st_next;
			aux_pkg::st_ack:
				if (acked)
					state_next = aux_pkg::st_done;
			aux_pkg::st_done:
				if (done_end)
					state_next = aux_pkg::st_next;
			aux_pkg::st_next:
				if (phase_reg)
					state_next = aux_pkg::st_idle;
				else if (motion_reg)
					state_next = aux_pkg::st_move;
				else
					state_next = aux_pkg::st_gap;
			aux_pkg::st_move:
				if (move_done)
					state_next = aux_pkg::st_gap;
			default:
				state_next = aux_pkg::st_idle;
		endcase
	end

	wire take_blk = (state_reg == aux_pkg::st_idle) & blk_valid;
	wire to_after = (state_reg == aux_pkg::st_next) & ~phase_reg;
	wire start_mv = to_after & motion_reg;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_reg <= aux_pkg::st_idle;
			phase_reg <= 1'b0;
			motion_reg <= 1'b0;
			idx_reg <= 3'h0;
			blk_codes_reg <= '0;
			blk_vld_reg <= '0;
			ready_reg <= 1'b0;
			move_reg <= 1'b0;
			strobe_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			ready_reg <= (state_next == aux_pkg::st_idle);
			move_reg <= start_mv;
			if (take_blk)
			begin
				blk_codes_reg <= blk_codes;
				blk_vld_reg <= blk_code_valid;
				motion_reg <= blk_motion;
				phase_reg <= 1'b0;
			end
			else if (to_after)
				phase_reg <= 1'b1;
			idx_reg <= (state_reg == aux_pkg::st_scan) ? idx_reg + 3'h1 : 3'h0;
			if (fire)
				strobe_reg <= 1'b1;
			else if (release_s)
				strobe_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Group collection in block order

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bef_n_reg <= 3'h0;
			aft_n_reg <= 3'h0;
			bef_wait_reg <= 1'b0;
			aft_wait_reg <= 1'b0;
		end
		else if (take_blk)
		begin
			bef_n_reg <= 3'h0;
			aft_n_reg <= 3'h0;
			bef_wait_reg <= 1'b0;
			aft_wait_reg <= 1'b0;
		end
		else
		begin
			if (add_bef)
			begin
				bef_n_reg <= bef_n_reg + 3'h1;
				bef_wait_reg <= bef_wait_reg | cur_wait;
			end
			if (add_aft)
			begin
				aft_n_reg <= aft_n_reg + 3'h1;
				aft_wait_reg <= aft_wait_reg | cur_wait;
			end
		end
	end

	generate
		for (genvar g = 0; g < `AUX_NUM_CODES; g++)
		begin : g_slot
			wire bef_hit = add_bef & (bef_n_reg == 3'(g));
			wire aft_hit = add_aft & (aft_n_reg == 3'(g));
			wire used = (3'(g) < grp_n);
			wire aux_pkg::m_code_t grp_code =
				phase_reg ? aft_code_reg[g] : bef_code_reg[g];

			always_ff @(posedge mclk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					bef_code_reg[g] <= '0;
					aft_code_reg[g] <= '0;
					code_reg[g] <= '0;
				end
				else
				begin
					if (bef_hit)
						bef_code_reg[g] <= cur_code;
					if (aft_hit)
						aft_code_reg[g] <= cur_code;
					// Loaded only at the cycle the strobe rises
					if (fire)
						code_reg[g] <= used ? grp_code : '0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign m_code_out_1 = code_reg[0];
	assign m_code_out_2 = code_reg[1];
	assign m_code_out_3 = code_reg[2];
	assign m_code_out_4 = code_reg[3];
	assign m_code_out_5 = code_reg[4];
	assign m_code_out_6 = code_reg[5];
	assign m_code_out_7 = code_reg[6];
	assign m_code_strobe = strobe_reg;
	assign blk_ready = ready_reg;
	assign move_start = move_reg;

endmodule : aux_function_strobe_handshake

// >>> src/aux_defs.svh
/*
 Constants of the auxiliary M function strobe handshake: group size,
 code width, function table layout and counter width.
 Assumes it is included by its bare name wherever the values are needed.
*/
`ifndef AUX_DEFS_SVH
`define AUX_DEFS_SVH

// Number of code outputs in one group
`define AUX_NUM_CODES 7
// Last group index
`define AUX_LAST_IDX 3'h6
// Width of one M function code
`define AUX_CODE_W 8
// Number of entries in the function table, one per code value
`define AUX_TBL_DEPTH 256
// Table entry layout
`define AUX_ENT_W 3
`define AUX_ENT_DEFINED 2
`define AUX_ENT_AFTER 1
`define AUX_ENT_WAIT 0
// Reset value of a table entry: not defined
`define AUX_ENT_RESET 3'h0
// Width of the handshake width counter, in bits; the count is in mclk cycles
`define AUX_CNT_W 16

`endif

// >>> src/aux_pkg.sv
/*
 Types of the auxiliary M function strobe handshake.
 Assumes aux_defs.svh is on the include path.
*/
`include "aux_defs.svh"

package aux_pkg;

	typedef logic [`AUX_CODE_W-1:0] m_code_t;
	typedef logic [`AUX_ENT_W-1:0] tbl_entry_t;
	typedef logic [`AUX_CNT_W-1:0] width_t;

	typedef enum logic [2:0] {
		st_idle,
		st_scan,
		st_gap,
		st_hold,
		st_ack,
		st_done,
		st_next,
		st_move
	} hs_state_e;

endpackage : aux_pkg

// >>> src/aux_func_table.sv
/*
 Function table: one entry per M code value telling whether the code is
 defined, whether it goes out after the move and whether it waits for done.
 Assumes one clock; written by configuration, read combinationally.
*/
`timescale 1ns/10ps
`include "aux_defs.svh"

module aux_func_table (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Configuration write
	input wire logic wr_en,
	input wire aux_pkg::m_code_t wr_code,
	input wire aux_pkg::tbl_entry_t wr_entry,
	// Lookup
	input wire aux_pkg::m_code_t rd_code,
	output aux_pkg::tbl_entry_t rd_entry
);

	aux_pkg::tbl_entry_t table_reg [`AUX_TBL_DEPTH];

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < `AUX_TBL_DEPTH; i++)
				table_reg[i] <= `AUX_ENT_RESET;
		end
		else if (wr_en)
			table_reg[wr_code] <= wr_entry;
	end

	assign rd_entry = table_reg[rd_code];

endmodule : aux_func_table

// >>> verif/aux_hs_properties.sv
/*
 Port checker of the M strobe handshake: widths, order, code stability.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps

module aux_hs_properties (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Watched ports
	input wire logic blk_valid,
	input wire logic blk_ready,
	input wire logic move_start,
	input wire aux_pkg::width_t min_handshake_width,
	input wire aux_pkg::m_code_t m_code_out_1,
	input wire aux_pkg::m_code_t m_code_out_2,
	input wire aux_pkg::m_code_t m_code_out_3,
	input wire aux_pkg::m_code_t m_code_out_4,
	input wire aux_pkg::m_code_t m_code_out_5,
	input wire aux_pkg::m_code_t m_code_out_6,
	input wire aux_pkg::m_code_t m_code_out_7,
	input wire logic m_code_strobe
);
	logic [16:0] hi_reg;
	logic [16:0] lo_reg;
	wire [16:0] w = {1'b0, min_handshake_width};
	wire [55:0] codes = {m_code_out_7, m_code_out_6, m_code_out_5,
		m_code_out_4, m_code_out_3, m_code_out_2, m_code_out_1};
	wire [16:0] lo_next = (lo_reg > w) ? lo_reg : lo_reg + 17'h00001;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Run lengths of strobe high and strobe low
	always_ff @(posedge mclk or negedge reset_n)
		if (!reset_n)
		begin
			hi_reg <= 17'h00000;
			lo_reg <= 17'h1ffff;
		end
		else
		begin
			hi_reg <= m_code_strobe ? hi_reg + 17'h00001 : 17'h00000;
			lo_reg <= m_code_strobe ? 17'h00000 : lo_next;
		end
	a_codes_hold:
	assert property (m_code_strobe && $past(m_code_strobe) |-> $stable(codes))
	else $error("codes moved while strobe high");
	a_codes_load:
	assert property ($changed(codes) |-> $rose(m_code_strobe))
	else $error("codes changed without strobe rise");
	a_strobe_width:
	assert property ($fell(m_code_strobe) |-> hi_reg > w)
	else $error("strobe high too short");
	a_strobe_gap:
	assert property ($rose(m_code_strobe) |-> lo_reg > w)
	else $error("strobe low gap too short");
	a_busy_stall:
	assert property (m_code_strobe |-> !blk_ready)
	else $error("ready while strobe high");
	a_move_pulse:
	assert property (move_start |=> !move_start)
	else $error("move start longer than one cycle");
	a_move_quiet:
	assert property (move_start |-> !m_code_strobe && !blk_ready)
	else $error("move start during strobe or idle");
	a_scan_slots:
	assert property (blk_valid && blk_ready |=> !blk_ready [*7])
	else $error("ready back before slot scan ends");
endmodule : aux_hs_properties

bind aux_function_strobe_handshake aux_hs_properties u_props (.mclk,
	.reset_n, .blk_valid, .blk_ready, .move_start, .min_handshake_width,
	.m_code_out_1, .m_code_out_2, .m_code_out_3, .m_code_out_4,
	.m_code_out_5, .m_code_out_6, .m_code_out_7, .m_code_strobe);

// >>> verif/aux_plc_model.sv
/*
 Machine logic controller model answering the M strobe with done.
 Assumes lag, in cycles, is set by the bench before each block.
*/
`timescale 1ns/10ps

module aux_plc_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Device side
	input wire logic m_code_strobe,
	input wire logic [31:0] lag,
	output logic aux_done_in
);
	logic seen_reg;
	int n_reg;
	// Done resets high, so a stale done is offered at each strobe unless the last one fell before lag ran out
	always_ff @(posedge mclk or negedge reset_n)
		if (!reset_n)
		begin
			aux_done_in <= 1'b1;
			seen_reg <= 1'b0;
			n_reg <= 0;
		end
		else if (m_code_strobe && !seen_reg)
		begin
			aux_done_in <= 1'b0;
			seen_reg <= 1'b1;
			n_reg <= lag;
		end
		else if (m_code_strobe && n_reg > 0)
			n_reg <= n_reg - 1;
		else if (m_code_strobe)
			aux_done_in <= 1'b1;
		else
			seen_reg <= 1'b0;
endmodule : aux_plc_model

// >>> verif/tb.sv
/*
 Bench of the M strobe handshake against a queue model of the groups.
 Assumes the design, its bound checker and the controller model.
*/
`timescale 1ns/10ps

module tb;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic blk_valid = 1'b0;
	logic [55:0] blk_codes = 56'h0;
	logic [6:0] blk_code_valid = 7'h00;
	logic blk_motion = 1'b0;
	logic move_done = 1'b0;
	logic tbl_wr_en = 1'b0;
	aux_pkg::m_code_t tbl_wr_code = 8'h00;
	aux_pkg::tbl_entry_t tbl_wr_entry = 3'h0;
	aux_pkg::width_t min_handshake_width = 16'h0002;
	aux_pkg::m_code_t m_code_out_1, m_code_out_2, m_code_out_3;
	aux_pkg::m_code_t m_code_out_4, m_code_out_5, m_code_out_6;
	aux_pkg::m_code_t m_code_out_7;
	logic blk_ready, move_start, m_code_strobe, aux_done_in;
	wire [56:0] shown = {1'b0, m_code_out_7, m_code_out_6, m_code_out_5,
		m_code_out_4, m_code_out_3, m_code_out_2, m_code_out_1};
	logic ps = 1'b0, wt = 1'b0;
	int fail_count = 0, total_checks = 0, seed = 32'h2e5b, cyc = 0;
	int lag = 0, hi = 0, dhi = 0;
	int tbl [256];
	logic [56:0] ev_q [$];
	logic wq [$];

	aux_function_strobe_handshake dut (.mclk, .reset_n, .blk_valid,
		.blk_codes, .blk_code_valid, .blk_motion, .blk_ready, .move_start,
		.move_done, .min_handshake_width, .tbl_wr_en, .tbl_wr_code,
		.tbl_wr_entry, .m_code_out_1, .m_code_out_2, .m_code_out_3,
		.m_code_out_4, .m_code_out_5, .m_code_out_6, .m_code_out_7,
		.m_code_strobe, .aux_done_in);
	aux_plc_model plc (.mclk, .reset_n, .m_code_strobe, .lag, .aux_done_in);

	////////////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	task automatic check_event(input logic [56:0] got, input logic [56:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: event %h not %h", $time, got, exp);
		end
	endtask : check_event

	task automatic check_width(input int got, input int exp);
		total_checks++;
		if (got != exp)
		begin
			fail_count++;
			$display("wrong value at %0t: count %0d not %0d", $time, got, exp);
		end
	endtask : check_width

	// Splits a block into groups as the table says, then offers it
	task automatic send_block(input logic [6:0] m, input logic mo);
		logic [55:0] cd, b, a;
		int nb, na, e;
		logic wb, wa;
		b = 56'h0;
		a = 56'h0;
		nb = 0;
		na = 0;
		wb = 1'b0;
		wa = 1'b0;
		for (int i = 0; i < 7; i++)
		begin
			cd[8*i+:8] = 8'(48 + ($random(seed) & 31));
			e = tbl[cd[8*i+:8]];
			if (m[i] && e[2] && e[1])
			begin
				a[8*na+:8] = cd[8*i+:8];
				na++;
				wa |= e[0];
			end
			else if (m[i])
			begin
				b[8*nb+:8] = cd[8*i+:8];
				nb++;
				wb |= !e[2] || e[0];
			end
		end
		if (nb > 0)
		begin
			ev_q.push_back({1'b0, b});
			wq.push_back(wb);
		end
		if (mo)
			ev_q.push_back({1'b1, 56'h0});
		if (na > 0)
		begin
			ev_q.push_back({1'b0, a});
			wq.push_back(wa);
		end
		while (blk_ready !== 1'b1)
			@(negedge mclk);
		lag = $random(seed) & 7;
		blk_valid = 1'b1;
		blk_codes = cd;
		blk_code_valid = m;
		blk_motion = mo;
		repeat (2) @(negedge mclk);
		blk_valid = 1'b0;
	endtask : send_block

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		forever #25 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			close_out;
		end
	end

	// Axis stand-in
	initial
	forever
	begin
		@(negedge mclk);
		if (move_start === 1'b1)
		begin
			repeat (lag) @(negedge mclk);
			move_done = 1'b1;
			@(negedge mclk);
			move_done = 1'b0;
		end
	end

	// Watches each strobe and move request against the queues
	always @(negedge mclk)
	begin
		if (m_code_strobe === 1'b1 && !ps)
		begin
			check_event(shown, ev_q.pop_front());
			wt = wq.pop_front();
		end
		if (m_code_strobe === 1'b0 && ps)
			check_width(wt ? dhi : hi, min_handshake_width + 1);
		if (move_start === 1'b1)
			check_event({1'b1, 56'h0}, ev_q.pop_front());
		hi = (m_code_strobe === 1'b1) ? hi + 1 : 0;
		dhi = (m_code_strobe === 1'b1 && aux_done_in === 1'b1) ? dhi + 1 : 0;
		ps = (m_code_strobe === 1'b1);
	end

	initial
	begin
		repeat (8) @(negedge mclk);
		reset_n = 1'b1;
		repeat (2) @(negedge mclk);
		for (int c = 48; c < 80; c++)
		begin
			tbl[c] = $random(seed) & 7;
			tbl_wr_en = 1'b1;
			tbl_wr_code = 8'(c);
			tbl_wr_entry = 3'(tbl[c]);
			@(negedge mclk);
		end
		tbl_wr_en = 1'b0;
		send_block(7'h7f, 1'b1);
		send_block(7'h7f, 1'b0);
		repeat (40) send_block(7'($random(seed)), 1'($random(seed)));
		while (blk_ready !== 1'b1 || m_code_strobe !== 1'b0)
			@(negedge mclk);
		repeat (4) @(negedge mclk);
		check_width(ev_q.size(), 0);
		close_out;
	end
endmodule : tb
